// file: design/ppm_cfg.svh
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH
// Register byte offsets
`define PPM_OFF_CTRL       12'h000
`define PPM_OFF_INFO       12'h004
`define PPM_OFF_PAGE       12'h008
`define PPM_OFF_SECI       12'h00c
`define PPM_OFF_ENV        12'h010
`define PPM_OFF_RESULT     12'h014
`define PPM_OFF_FLAGS      12'h018
`define PPM_OFF_EXIT       12'h01c
`define PPM_OFF_ENTRY_SEL  12'h020
`define PPM_OFF_ENTRY_VAL  12'h024
`define PPM_OFF_IRQ_STAT   12'h028
`define PPM_OFF_IRQ_MASK   12'h02c
`define PPM_OFF_WIPE       12'h030
// Page type codes
`define PPM_REGULAR_PAGE_TYPE         3'h2
`define PPM_THREAD_CONTROL_TYPE         3'h1
`define PPM_TRIMMED_TYPE        3'h4
`define PPM_VERSION_ARRAY_TYPE          3'h3
// Result codes
`define PPM_RC_OK          32'h00000000
`define PPM_RC_CONFLICT    32'h00000007
`define PPM_RC_NOT_MOD     32'h00000014
// Exit qualifier codes
`define PPM_Q_EXCEPTION    2'h1
`define PPM_Q_ERROR        2'h2
// Alignment widths in address bits
`define PPM_INFO_ALIGN     6
`define PPM_PAGE_ALIGN     12
// Page wipe length in 32-bit words: 32768 bits
`define PPM_PAGE_BITS      32768
`define PPM_WIPE_WORDS     (`PPM_PAGE_BITS / 32)
`endif

// file: design/ppm_pkg.sv
package ppm_pkg;
	typedef enum logic [1:0] {
		PPM_OUT_OK,
		PPM_OUT_ERR,
		PPM_OUT_GP,
		PPM_OUT_PF
	} ppm_outcome_e;

	// One page map entry
	typedef struct packed {
		logic        valid;
		logic [2:0]  ptype;
		logic        blocked;
		logic        pending;
		logic        modified;
		logic        restrict_pend;
		logic [2:0]  rwx;
		logic [19:0] encl_addr;
	} ppm_entry_s;
endpackage : ppm_pkg

// file: design/ppm_wipe_if.sv
`timescale 1ns/1ps
interface ppm_wipe_if;
	logic        start;
	logic [31:0] base;
	logic        busy;
	logic        done;
	logic        we;
	logic [31:0] addr;
	modport ctl (output start, output base, input busy, input done, input we, input addr);
	modport eng (input start, input base, output busy, output done, output we, output addr);
endinterface : ppm_wipe_if

// file: design/ppm_wipe.sv
`timescale 1ns/1ps
`include "ppm_cfg.svh"
module ppm_wipe #(
	parameter int WORDS = `PPM_WIPE_WORDS
) (
	input  wire logic clock,
	input  wire logic rst_b,
	ppm_wipe_if.eng   w
);
	typedef struct packed {
		logic        busy;
		logic        done;
		logic [31:0] idx;
	} ppm_wst_s;
	ppm_wst_s s_q;
	ppm_wst_s s_d;

	// Steps one word per cycle through the page, zeroing it
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (s_q.busy) begin
			if (s_q.idx == 32'(WORDS - 1)) begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
			end else begin
				s_d.idx = s_q.idx + 32'h00000001;
			end
		end else if (w.start) begin
			s_d.busy = 1'b1;
			s_d.idx  = 32'h00000000;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign w.busy = s_q.busy;
	assign w.done = s_q.done;
	assign w.we   = s_q.busy;
	assign w.addr = w.base + {s_q.idx[29:0], 2'h0};
endmodule : ppm_wipe

// file: design/ppm_top.sv
`timescale 1ns/1ps
`include "ppm_cfg.svh"
module ppm_top #(
	parameter int ENTRIES = 16,
	parameter int WIPE_WORDS = `PPM_WIPE_WORDS
) (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        first_gen_busy,
	input  wire logic        second_gen_busy,
	input  wire logic        writer_busy,
	output logic             irq,
	output logic             wipe_we,
	output logic [31:0]      wipe_addr
);
	localparam int IW = $clog2(ENTRIES);

	typedef enum logic [1:0] {
		PPM_IDLE,
		PPM_WIPE,
		PPM_DONE
	} ppm_state_e;

	// Whole module state
	typedef struct packed {
		ppm_state_e  st;
		logic        aw_ok;
		logic        w_ok;
		logic [11:0] awaddr;
		logic [31:0] wdata;
		logic        bvalid;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [1:0]  bresp;
		logic [31:0] info_ptr;
		logic [31:0] page_ptr;
		logic [31:0] seci;
		logic [3:0]  env;
		logic [31:0] result;
		logic [5:0]  flags;
		logic [1:0]  outcome;
		logic [1:0]  exit_q;
		logic        exit_taken;
		logic [IW-1:0] sel;
		logic [2:0]  irq_stat;
		logic [2:0]  irq_mask;
		logic        irq;
		logic        start;
		logic [IW-1:0] tgt;
		ppm_pkg::ppm_entry_s [ENTRIES-1:0] map;
	} ppm_st_s;
	ppm_st_s s_q;
	ppm_st_s s_d;

	ppm_wipe_if wif ();

	ppm_wipe #(
		.WORDS (WIPE_WORDS)
	) u_wipe (
		.clock (clock),
		.rst_b (rst_b),
		.w     (wif.eng)
	);

	////////////////////////////////////////////////////////////////////////////
	// Operation evaluation
	// env: bit0 enclave initialised, bit1 guest mode, bit2 page virt ext,
	// bit3 target resolves in page cache. seci: [2:0] requested type,
	// [31:3] reserved. ctrl write: bit0 type change, bit1 add version array.
	logic [IW-1:0]        idx;
	ppm_pkg::ppm_entry_s  cur;
	ppm_pkg::ppm_entry_s  upd;
	logic [1:0]           oc;
	logic [31:0]          rc;
	logic                 zf;
	logic                 vmexit;
	logic                 do_tc;
	logic                 do_va;
	logic                 wr_go;

	always_comb begin
		idx    = s_q.page_ptr[`PPM_PAGE_ALIGN +: IW];
		cur    = s_q.map[idx];
		upd    = cur;
		oc     = ppm_pkg::PPM_OUT_OK;
		rc     = `PPM_RC_OK;
		zf     = 1'b0;
		vmexit = 1'b0;
		if (do_tc) begin
			if (s_q.info_ptr[`PPM_INFO_ALIGN-1:0] != '0 || s_q.page_ptr[`PPM_PAGE_ALIGN-1:0] != '0) begin
				oc = ppm_pkg::PPM_OUT_GP;
			end else if (!s_q.env[3]) begin
				oc = ppm_pkg::PPM_OUT_PF;
			end else if (s_q.seci[31:3] != '0 ||
				!(s_q.seci[2:0] == `PPM_THREAD_CONTROL_TYPE || s_q.seci[2:0] == `PPM_TRIMMED_TYPE)) begin
				oc = ppm_pkg::PPM_OUT_GP;
			end else if (first_gen_busy || writer_busy) begin
				oc = ppm_pkg::PPM_OUT_ERR;
				rc = `PPM_RC_CONFLICT;
				zf = 1'b1;
			end else if (!cur.valid) begin
				oc = ppm_pkg::PPM_OUT_PF;
			end else if (second_gen_busy) begin
				oc = ppm_pkg::PPM_OUT_ERR;
				rc = `PPM_RC_CONFLICT;
				zf = 1'b1;
			end else if (!(cur.ptype == `PPM_REGULAR_PAGE_TYPE ||
				(cur.ptype == `PPM_THREAD_CONTROL_TYPE && s_q.seci[2:0] == `PPM_TRIMMED_TYPE))) begin
				oc = ppm_pkg::PPM_OUT_PF;
			end else if (cur.pending || cur.modified) begin
				oc = ppm_pkg::PPM_OUT_ERR;
				rc = `PPM_RC_NOT_MOD;
				zf = 1'b1;
			end else if (!s_q.env[0]) begin
				oc = ppm_pkg::PPM_OUT_GP;
			end else begin
				upd.restrict_pend = 1'b0;
				upd.modified      = 1'b1;
				upd.rwx           = 3'h0;
				upd.ptype         = s_q.seci[2:0];
			end
		end else begin
			if (s_q.info_ptr != 32'({29'h0, `PPM_VERSION_ARRAY_TYPE}) || s_q.page_ptr[`PPM_PAGE_ALIGN-1:0] != '0) begin
				oc = ppm_pkg::PPM_OUT_GP;
			end else if (!s_q.env[3]) begin
				oc = ppm_pkg::PPM_OUT_PF;
			end else if (first_gen_busy || second_gen_busy || writer_busy) begin
				if (s_q.env[1] && s_q.env[2]) begin
					vmexit = 1'b1;
				end else begin
					oc = ppm_pkg::PPM_OUT_GP;
				end
			end else if (cur.valid) begin
				oc = ppm_pkg::PPM_OUT_PF;
			end else begin
				upd           = '0;
				upd.ptype     = `PPM_VERSION_ARRAY_TYPE;
				upd.valid     = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus handshake and next state
	always_comb begin
		s_d   = s_q;
		do_tc = 1'b0;
		do_va = 1'b0;
		wr_go = 1'b0;
		if (s_axi_awvalid && !s_q.aw_ok) begin
			s_d.aw_ok  = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_ok) begin
			s_d.w_ok  = 1'b1;
			s_d.wdata = s_axi_wdata;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		// Writes wait while an operation runs so operands never shift under it
		if (s_q.aw_ok && s_q.w_ok && !s_q.bvalid && s_q.st == PPM_IDLE && !s_q.start) begin
			wr_go      = 1'b1;
			s_d.aw_ok  = 1'b0;
			s_d.w_ok   = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = 2'h0;
			unique case (s_q.awaddr)
				`PPM_OFF_CTRL: begin
					if (s_q.wdata[0] || s_q.wdata[1]) begin
						s_d.start = 1'b1;
						s_d.exit_q = {1'b0, s_q.wdata[1]};
					end
				end
				`PPM_OFF_INFO: s_d.info_ptr = s_q.wdata;
				`PPM_OFF_PAGE: s_d.page_ptr = s_q.wdata;
				`PPM_OFF_SECI: s_d.seci = s_q.wdata;
				`PPM_OFF_ENV: s_d.env = s_q.wdata[3:0];
				`PPM_OFF_ENTRY_SEL: s_d.sel = s_q.wdata[IW-1:0];
				`PPM_OFF_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~s_q.wdata[2:0];
				`PPM_OFF_IRQ_MASK: s_d.irq_mask = s_q.wdata[2:0];
				default: s_d.bresp = 2'h2;
			endcase
		end
		if (s_axi_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = 2'h0;
			unique case (s_axi_araddr)
				`PPM_OFF_CTRL: s_d.rdata = {30'h0, s_q.st != PPM_IDLE, s_q.start};
				`PPM_OFF_INFO: s_d.rdata = s_q.info_ptr;
				`PPM_OFF_PAGE: s_d.rdata = s_q.page_ptr;
				`PPM_OFF_SECI: s_d.rdata = s_q.seci;
				`PPM_OFF_ENV: s_d.rdata = {28'h0, s_q.env};
				`PPM_OFF_RESULT: s_d.rdata = s_q.result;
				`PPM_OFF_FLAGS: s_d.rdata = {24'h0, s_q.outcome, s_q.flags};
				`PPM_OFF_EXIT: s_d.rdata = {29'h0, s_q.exit_taken, s_q.exit_q};
				`PPM_OFF_ENTRY_SEL: s_d.rdata = 32'(s_q.sel);
				`PPM_OFF_ENTRY_VAL: s_d.rdata = {s_q.map[s_q.sel], 1'b0};
				`PPM_OFF_IRQ_STAT: s_d.rdata = {29'h0, s_q.irq_stat};
				`PPM_OFF_IRQ_MASK: s_d.rdata = {29'h0, s_q.irq_mask};
				`PPM_OFF_WIPE: s_d.rdata = {31'h0, wif.busy};
				default: begin
					s_d.rdata = 32'h00000000;
					s_d.rresp = 2'h2;
				end
			endcase
		end

		// Evaluate one cycle after launch; bit0 of exit_q holds the leaf choice
		if (s_q.start) begin
			s_d.start = 1'b0;
			do_va = s_q.exit_q[0];
			do_tc = !s_q.exit_q[0];
		end
		if (do_tc || do_va) begin
			s_d.outcome    = oc;
			s_d.exit_taken = vmexit;
			s_d.exit_q     = vmexit ? `PPM_Q_EXCEPTION : 2'h0;
			s_d.tgt        = idx;
			if (oc == ppm_pkg::PPM_OUT_ERR || (do_tc && oc == ppm_pkg::PPM_OUT_OK)) begin
				s_d.result = rc;
				s_d.flags  = {5'h00, zf};
			end
			// Faults and errors leave the entry alone
			if (oc == ppm_pkg::PPM_OUT_OK && !vmexit) begin
				if (do_va) begin
					s_d.st = PPM_WIPE;
				end else begin
					s_d.map[idx] = upd;
					s_d.st = PPM_DONE;
				end
			end else begin
				s_d.st = PPM_DONE;
			end
		end
		// Entry goes valid only after the page is fully zeroed
		if (s_q.st == PPM_WIPE && wif.done) begin
			s_d.map[s_q.tgt] = '0;
			s_d.map[s_q.tgt].ptype = `PPM_VERSION_ARRAY_TYPE;
			s_d.map[s_q.tgt].valid = 1'b1;
			s_d.st = PPM_DONE;
		end
		if (s_q.st == PPM_DONE) begin
			s_d.st = PPM_IDLE;
		end

		// Sticky events: done, fault, vm exit; set beats a same-cycle clear
		if (s_q.st == PPM_DONE) begin
			s_d.irq_stat[0] = 1'b1;
			if (s_q.outcome == ppm_pkg::PPM_OUT_GP || s_q.outcome == ppm_pkg::PPM_OUT_PF) begin
				s_d.irq_stat[1] = 1'b1;
			end
			if (s_q.exit_taken) begin
				s_d.irq_stat[2] = 1'b1;
			end
		end
		s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
	end

	assign wif.start = (do_va && oc == ppm_pkg::PPM_OUT_OK && !vmexit);
	assign wif.base  = s_q.page_ptr;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = s_axi_arvalid && !s_q.rvalid;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;
	assign irq           = s_q.irq;
	assign wipe_we       = wif.we;
	assign wipe_addr     = wif.addr;
endmodule : ppm_top

// file: test/ppm_props.sv
`timescale 1ns/1ps
module ppm_props #(
	parameter int WIPE_WORDS = 8
) (
	input wire logic        clock,
	input wire logic        rst_b,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        wipe_we,
	input wire logic [31:0] wipe_addr
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	int wlen_q;
	// Burst length in a counter, since a wipe outruns any repetition
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) wlen_q <= 0;
		else wlen_q <= wipe_we ? wlen_q + 1 : 0;
	end
	sequence wipe_step;
		wipe_we ##1 wipe_we;
	endsequence
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rd");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid");
	ar_take_a: assert property (s_axi_arvalid && !s_axi_rvalid |-> s_axi_arready) else $error("ar");
	r_next_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("rvalid");
	w_pair_a: assert property (s_axi_awready == s_axi_wready) else $error("aw w");
	b_soon_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:2] s_axi_bvalid) else $error("b late");
	b_one_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("b busy");
	wipe_addr_a: assert property (wipe_step |-> wipe_addr == $past(wipe_addr) + 32'h4) else $error("step");
	wipe_len_a: assert property ($fell(wipe_we) |-> $past(wlen_q) + 1 == WIPE_WORDS) else $error("len");
endmodule : ppm_props
bind ppm_top ppm_props #(.WIPE_WORDS(WIPE_WORDS)) u_props (.*);

// file: test/ppm_peer.sv
`timescale 1ns/1ps
module ppm_peer (
	input wire logic       clock,
	input wire logic       rst_b,
	input wire logic [2:0] sel,
	output logic           first_gen_busy,
	output logic           second_gen_busy,
	output logic           writer_busy
);
	// Other users of the page hold their claim steady across a whole request
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) {first_gen_busy, second_gen_busy, writer_busy} <= 3'h0;
		else {writer_busy, second_gen_busy, first_gen_busy} <= sel;
	end
endmodule : ppm_peer

// file: test/ppm_top_tb.sv
`timescale 1ns/1ps
`include "ppm_cfg.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; $display("FAIL %0t %h %h", $time, a, b); end end
module ppm_top_tb;
	localparam int WW = 8;
	logic        clock, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, msk, q;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, wipe_we;
	logic        first_gen_busy, second_gen_busy, writer_busy;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, wipe_addr, d, page, pg;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
	logic [2:0]  sel;
	int          errors, tests_run, cyc, wk, mv[16];

	ppm_top #(.WIPE_WORDS(WW)) dut (.*);
	ppm_peer peer (.*);

	// System clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task end_sim;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	// Ceiling well above the under a thousand cycles the sequence needs
	always @(posedge clock) begin
		cyc++;
		if (cyc == 6000) begin
			errors++;
			end_sim();
		end
	end

	// Zeroed words must walk the page one word per cycle; looked at mid-cycle, where the strobe is settled
	always @(negedge clock) begin
		if (wipe_we) begin
			`CHK(wipe_addr, page + 32'(4 * wk))
			wk++;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Waits for a ready or valid seen high at a settled point; snapshots the answer
	task automatic hs(ref logic r);
		logic t;
		do begin
			@(negedge clock);
			t = r;
			d = s_axi_rdata;
			rr = s_axi_rresp;
			br = s_axi_bresp;
			q = irq;
			@(posedge clock);
		end while (!t);
	endtask : hs

	// The slave raises both write readies together, so both channels drop at once
	task wr(input logic [11:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		hs(s_axi_awready);
		{s_axi_awvalid, s_axi_wvalid} <= 2'h0;
		hs(s_axi_bvalid);
		s_axi_bready <= 1'b0;
		@(posedge clock);
	endtask : wr

	task rd(input logic [11:0] a);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		hs(s_axi_arready);
		s_axi_arvalid <= 1'b0;
		hs(s_axi_rvalid);
		s_axi_rready <= 1'b0;
		@(posedge clock);
	endtask : rd

	// One request; x is 0 done, 1 error exit, 2 protection fault, 3 page fault, 4 guest exit
	task run(input int k, input logic [31:0] i, p, s, e, input logic [2:0] b);
		int x;
		x = 0;
		sel <= b;
		page = p;
		wk = 0;
		if (k == 2) begin
			if (i != 32'(`PPM_VERSION_ARRAY_TYPE) || p[11:0] != 12'h0) x = 2;
			else if (!e[3]) x = 3;
			else if (b != 3'h0) x = e[2:1] == 2'h3 ? 4 : 2;
			else if (mv[p[15:12]] != 0) x = 3;
			else mv[p[15:12]] = 1;
		end else if (i[5:0] != 6'h0 || p[11:0] != 12'h0) x = 2;
		else if (!e[3]) x = 3;
		else if (s[31:3] != 29'h0 || !(s[2:0] == `PPM_THREAD_CONTROL_TYPE || s[2:0] == `PPM_TRIMMED_TYPE)) x = 2;
		else if (b[0] || b[2]) x = 1;
		else if (mv[p[15:12]] == 0 || !b[1]) x = 3;
		else x = 1;
		wr(`PPM_OFF_INFO, i);
		wr(`PPM_OFF_PAGE, p);
		wr(`PPM_OFF_SECI, s);
		wr(`PPM_OFF_ENV, e);
		wr(`PPM_OFF_CTRL, 32'(k));
		do rd(`PPM_OFF_CTRL); while (d[1:0] != 2'h0);
		rd(`PPM_OFF_FLAGS);
		`CHK(d[5:1], 5'h0)
		if (x == 4) begin
			rd(`PPM_OFF_EXIT);
			`CHK(d[2:0], {1'b1, `PPM_Q_EXCEPTION})
		end else begin
			`CHK(d[7:6], 2'(x))
		end
		if (x == 1) begin
			`CHK(d[0], 1'b1)
			rd(`PPM_OFF_RESULT);
			`CHK(d, `PPM_RC_CONFLICT)
		end
		if (x == 0) begin
			`CHK(wk, WW)
			wr(`PPM_OFF_ENTRY_SEL, 32'(p[15:12]));
			rd(`PPM_OFF_ENTRY_VAL);
			`CHK(d, {1'b1, `PPM_VERSION_ARRAY_TYPE, 28'h0})
		end
		`CHK(q, msk)
		wr(`PPM_OFF_IRQ_STAT, 32'h7);
		rd(`PPM_OFF_IRQ_STAT);
		`CHK({q, d[2:0]}, 4'h0)
	endtask : run

	// Reset, then both leaves through their checks in order
	initial begin
		void'($urandom(84));
		{rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, msk} = 7'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, sel} = 59'h0;
		s_axi_wstrb = 4'hf;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		pg = {16'h0, 4'($urandom), 12'h0};
		run(1, 0, pg, 1, 9, 0);
		wr(`PPM_OFF_IRQ_MASK, 32'h7);
		msk = 1'b1;
		for (int t = 0; t < 8; t++) run(1, 0, pg, t, 9, 0);
		run(1, 32'h20, pg, 1, 9, 0);
		run(1, 0, pg | 32'h800, 1, 9, 0);
		run(1, 0, pg, 1, 1, 0);
		run(1, 0, pg, {29'($urandom) | 29'h1, 3'h1}, 9, 0);
		run(1, 0, pg, 1, 9, 1);
		run(1, 0, pg, 4, 9, 4);
		run(2, 2, pg, 0, 9, 0);
		run(2, 3, pg | 32'h40, 0, 9, 0);
		run(2, 3, pg, 0, 1, 0);
		run(2, 3, pg, 0, 9, 1);
		run(2, 3, pg, 0, 15, 1);
		run(2, 3, pg, 0, 9, 0);
		run(2, 3, pg, 0, 9, 0);
		run(1, 0, pg, 4, 9, 2);
		run(1, 0, pg, 4, 9, 0);
		rd(12'h03c);
		`CHK({rr, d}, 34'h200000000)
		wr(12'h03c, 32'h0);
		`CHK(br, 2'h2)
		wr(`PPM_OFF_IRQ_MASK, 32'h7);
		`CHK(br, 2'h0)
		end_sim();
	end
endmodule : ppm_top_tb
